// ==== verilog/ccdr_readout.v ====
// Purpose: Timing generator that reads a full frame out of a full-frame CCD.
// Assumes: An external converter samples the video output and hands back a word per pixel.
// Notes: Pixels are tagged with a class and pass through a FIFO to the sink.
// Notes on behaviour
// - Each line begins with 11 dummy pixels that are never used as dark reference.
// - The 4 pixels after the dummies are test pixels and are kept out of the dark reference.
// - The last three pixels of each line are test pixels and are kept out of the dark reference.
// - A frame has 4145 pixel positions per line and 4128 lines, all of which are clocked out.
// - Both vertical phases stay low during integration.
// - A line enters the horizontal register on the falling edge of vertical phase b while horizontal phase a is high.
// - Horizontal phases a and b toggle complementarily, one pair per pixel.
// - The diffusion clear gate pulses after each pixel is sampled, before the next arrives.
// - Vertical pulses are at least 20 us wide.
`timescale 1ns/1ns
`include "ccdr_defs.vh"
module ccdr_readout #(
  parameter DATA_W = 16,
  parameter FIFO_DEPTH = 16,
  parameter VPULSE_CYC = `CCDR_VPULSE_CYC,
  parameter HHALF_CYC = `CCDR_HHALF_CYC,
  parameter LINE_PIX = `CCDR_LINE_PIX,
  parameter FRAME_LINES = `CCDR_FRAME_LINES
) (
  input wire CLK_I,
  input wire RST_I,
  input wire START_I,
  input wire [DATA_W-1:0] SAMPLE_DATA_I,
  input wire SAMPLE_VALID_I,
  input wire PIX_READY_I,
  output reg VERT_PHASE_A_O,
  output reg VERT_PHASE_B_O,
  output reg HORIZ_PHASE_A_O,
  output reg HORIZ_PHASE_B_O,
  output reg DIFFUSION_CLEAR_GATE_O,
  output reg SAMPLE_REQ_O,
  output wire PIX_VALID_O,
  output wire [DATA_W+3:0] PIX_DATA_O,
  output reg BUSY_O,
  output reg FRAME_DONE_O,
  output reg [15:0] DARK_REF_O
);
  localparam ST_IDLE = 3'h0;
  localparam ST_V1 = 3'h1;
  localparam ST_V2 = 3'h2;
  localparam ST_V3 = 3'h3;
  localparam ST_HLOW = 3'h4;
  localparam ST_HHIGH = 3'h5;
  localparam ST_WAIT = 3'h6;
  localparam ST_CLR = 3'h7;

  reg [2:0] state;
  reg [31:0] timer;
  reg [12:0] pix;
  reg [12:0] line;
  reg start_s1;
  reg start_s2;
  reg samp_v1;
  reg samp_v2;
  reg samp_v3;
  reg [DATA_W-1:0] samp_d1;
  reg [DATA_W-1:0] samp_d2;
  reg [DATA_W+3:0] fifo_in;
  reg fifo_wr;
  reg [DATA_W+4:0] dark_sum;
  reg samp_pend;
  wire fifo_ready;
  wire samp_rise;
  wire timer_done;

  // Position class of a pixel inside a line
  function [2:0] pix_class;
    input [12:0] p;
    begin
      if (p < `CCDR_DUMMY_PIX) begin
        pix_class = `CCDR_CLASS_DUMMY;
      end else if (p < `CCDR_DUMMY_PIX + `CCDR_TEST_LEAD_PIX) begin
        pix_class = `CCDR_CLASS_TEST;
      end else if (p >= LINE_PIX - `CCDR_TEST_TAIL_PIX) begin
        pix_class = `CCDR_CLASS_TEST;
      end else if (p < `CCDR_DUMMY_PIX + `CCDR_TEST_LEAD_PIX + `CCDR_DARK_PIX) begin
        pix_class = `CCDR_CLASS_DARK;
      end else if (p == `CCDR_DUMMY_PIX + `CCDR_TEST_LEAD_PIX + `CCDR_DARK_PIX
                   || p >= LINE_PIX - `CCDR_TEST_TAIL_PIX - `CCDR_BUF_PIX) begin
        pix_class = `CCDR_CLASS_BUF;
      end else begin
        pix_class = `CCDR_CLASS_ACTIVE;
      end
    end
  endfunction

  // Line class overrides only the active pixel class, in dark and buffer rows
  function [2:0] full_class;
    input [12:0] p;
    input [12:0] l;
    reg [2:0] pc;
    begin
      pc = pix_class(p);
      if (pc != `CCDR_CLASS_ACTIVE) begin
        full_class = pc;
      end else if (l < `CCDR_DARK_LEAD_LINES || l >= FRAME_LINES - `CCDR_DARK_TAIL_LINES) begin
        full_class = `CCDR_CLASS_DARK;
      end else if (l == `CCDR_DARK_LEAD_LINES
                   || l == FRAME_LINES - `CCDR_DARK_TAIL_LINES - `CCDR_BUF_LINES) begin
        full_class = `CCDR_CLASS_BUF;
      end else begin
        full_class = `CCDR_CLASS_ACTIVE;
      end
    end
  endfunction

  assign timer_done = (timer == 32'h00000000);
  assign samp_rise = samp_v2 && !samp_v3;

  // Pins from the converter cross into this domain
  always @(posedge CLK_I) begin
    if (RST_I) begin
      start_s1 <= 1'b0;
      start_s2 <= 1'b0;
      samp_v1 <= 1'b0;
      samp_v2 <= 1'b0;
      samp_v3 <= 1'b0;
      samp_d1 <= {DATA_W{1'b0}};
      samp_d2 <= {DATA_W{1'b0}};
    end else begin
      start_s1 <= START_I;
      start_s2 <= start_s1;
      samp_v1 <= SAMPLE_VALID_I;
      samp_v2 <= samp_v1;
      samp_v3 <= samp_v2;
      samp_d1 <= SAMPLE_DATA_I;
      samp_d2 <= samp_d1;
    end
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      state <= ST_IDLE;
      timer <= 32'h00000000;
      pix <= 13'h0000;
      line <= 13'h0000;
      VERT_PHASE_A_O <= 1'b0;
      VERT_PHASE_B_O <= 1'b0;
      HORIZ_PHASE_A_O <= 1'b1;
      HORIZ_PHASE_B_O <= 1'b0;
      DIFFUSION_CLEAR_GATE_O <= 1'b0;
      SAMPLE_REQ_O <= 1'b0;
      BUSY_O <= 1'b0;
      FRAME_DONE_O <= 1'b0;
      DARK_REF_O <= 16'h0000;
      fifo_in <= {(DATA_W+4){1'b0}};
      fifo_wr <= 1'b0;
      dark_sum <= {(DATA_W+5){1'b0}};
      samp_pend <= 1'b0;
    end else begin
      FRAME_DONE_O <= 1'b0;
      fifo_wr <= 1'b0;
      if (!timer_done) begin
        timer <= timer - 32'h00000001;
      end
      case (state)
        ST_IDLE: begin
          // Integration: vertical clocks held low
          VERT_PHASE_A_O <= 1'b0;
          VERT_PHASE_B_O <= 1'b0;
          HORIZ_PHASE_A_O <= 1'b1;
          HORIZ_PHASE_B_O <= 1'b0;
          if (start_s2) begin
            BUSY_O <= 1'b1;
            line <= 13'h0000;
            // Reference is per frame, so the sum starts over
            dark_sum <= {(DATA_W+5){1'b0}};
            state <= ST_V1;
            VERT_PHASE_A_O <= 1'b1;
            timer <= VPULSE_CYC - 1;
          end
        end
        ST_V1: begin
          if (timer_done) begin
            VERT_PHASE_A_O <= 1'b0;
            VERT_PHASE_B_O <= 1'b1;
            timer <= VPULSE_CYC - 1;
            state <= ST_V2;
          end
        end
        ST_V2: begin
          if (timer_done) begin
            // Line lands in the horizontal register here, phase a still high
            VERT_PHASE_B_O <= 1'b0;
            HORIZ_PHASE_A_O <= 1'b1;
            timer <= VPULSE_CYC - 1;
            state <= ST_V3;
          end
        end
        ST_V3: begin
          if (timer_done) begin
            pix <= 13'h0000;
            HORIZ_PHASE_A_O <= 1'b0;
            HORIZ_PHASE_B_O <= 1'b1;
            timer <= HHALF_CYC - 1;
            state <= ST_HLOW;
          end
        end
        ST_HLOW: begin
          if (timer_done) begin
            HORIZ_PHASE_A_O <= 1'b1;
            HORIZ_PHASE_B_O <= 1'b0;
            SAMPLE_REQ_O <= 1'b1;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Charge sits on the diffusion until the converter has it
          // The converter holds valid while requested, so a missed edge never comes again; keep it pending
          if ((samp_rise || samp_pend) && fifo_ready) begin
            samp_pend <= 1'b0;
            SAMPLE_REQ_O <= 1'b0;
            fifo_in <= {1'b0, full_class(pix, line), samp_d2};
            fifo_wr <= 1'b1;
            if (line == `CCDR_DARK_LEAD_LINES - 1
                && full_class(pix, line) == `CCDR_CLASS_DARK) begin
              dark_sum <= dark_sum + {5'h00, samp_d2};
            end
            DIFFUSION_CLEAR_GATE_O <= 1'b1;
            timer <= HHALF_CYC - 1;
            state <= ST_CLR;
          end else if (samp_rise) begin
            samp_pend <= 1'b1;
          end
        end
        ST_CLR: begin
          if (timer_done) begin
            DIFFUSION_CLEAR_GATE_O <= 1'b0;
            if (pix == LINE_PIX - 1) begin
              // Only after the whole line is out does the next vertical transfer begin
              if (line == `CCDR_DARK_LEAD_LINES - 1) begin
                DARK_REF_O <= dark_sum[DATA_W+4:DATA_W-11];
              end
              if (line == FRAME_LINES - 1) begin
                state <= ST_IDLE;
                BUSY_O <= 1'b0;
                FRAME_DONE_O <= 1'b1;
              end else begin
                line <= line + 13'h0001;
                VERT_PHASE_A_O <= 1'b1;
                timer <= VPULSE_CYC - 1;
                state <= ST_V1;
              end
            end else begin
              pix <= pix + 13'h0001;
              HORIZ_PHASE_A_O <= 1'b0;
              HORIZ_PHASE_B_O <= 1'b1;
              timer <= HHALF_CYC - 1;
              state <= ST_HLOW;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ccdr_fifo #(
    .WIDTH(DATA_W + 4),
    .DEPTH(FIFO_DEPTH),
    .AW($clog2(FIFO_DEPTH))
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .in_valid_i(fifo_wr),
    .in_ready_o(fifo_ready),
    .in_data_i(fifo_in),
    .out_valid_o(PIX_VALID_O),
    .out_ready_i(PIX_READY_I),
    .out_data_o(PIX_DATA_O)
  );
endmodule // ccdr_readout

// ==== verilog/ccdr_defs.vh ====
// Purpose: Constants for the CCD readout sequencer.
// Assumes: 125 MHz system clock.
// Notes: The vertical pulse is given in us and its cycle count derives from it; the horizontal half period is given in cycles.
`ifndef CCDR_DEFS_VH
`define CCDR_DEFS_VH
`define CCDR_CLK_MHZ 125
`define CCDR_LINE_PIX 4145
`define CCDR_FRAME_LINES 4128
`define CCDR_EFF_PIX 4127
`define CCDR_ACT_PIX 4096
`define CCDR_ACT_LINES 4096
`define CCDR_DUMMY_PIX 11
`define CCDR_TEST_LEAD_PIX 4
`define CCDR_DARK_PIX 20
`define CCDR_BUF_PIX 1
`define CCDR_TEST_TAIL_PIX 3
`define CCDR_DARK_LEAD_LINES 20
`define CCDR_DARK_TAIL_LINES 9
`define CCDR_BUF_LINES 1
`define CCDR_VPULSE_US 20
`define CCDR_VPULSE_CYC (`CCDR_VPULSE_US * `CCDR_CLK_MHZ)
`define CCDR_HHALF_CYC 16
`define CCDR_CLASS_DUMMY 3'h0
`define CCDR_CLASS_TEST 3'h1
`define CCDR_CLASS_DARK 3'h2
`define CCDR_CLASS_BUF 3'h3
`define CCDR_CLASS_ACTIVE 3'h4
`endif

// ==== verilog/ccdr_fifo.v ====
// Purpose: Small synchronous FIFO for pixel samples.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Read data come out of a register.
`timescale 1ns/1ns
module ccdr_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output reg out_valid_o,
  input wire out_ready_i,
  output reg [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;
  wire load_out;
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign do_wr = in_valid_i && in_ready_o;
  // Output register refills whenever empty or being drained
  assign load_out = (!out_valid_o || out_ready_i) && (count != {(AW+1){1'b0}});
  assign do_rd = load_out;
  always @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o <= {WIDTH{1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
        out_data_o <= mem[rd_ptr];
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
      count <= count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule // ccdr_fifo

// ==== verif/ccdr_readout_sva.sv ====
// Purpose: Pin-level checks for the frame readout sequencer.
// Assumes: Single clock with synchronous reset; bound from tb_top.
// Notes: Pulse widths and pixel and line counts are measured by counters.
`timescale 1ns/1ns
module ccdr_readout_sva #(
  parameter VPULSE_CYC = 4,
  parameter LINE_PIX = 44,
  parameter FRAME_LINES = 32
) (
  input wire CLK_I,
  input wire RST_I,
  input wire VERT_PHASE_A_O,
  input wire VERT_PHASE_B_O,
  input wire HORIZ_PHASE_A_O,
  input wire HORIZ_PHASE_B_O,
  input wire DIFFUSION_CLEAR_GATE_O,
  input wire SAMPLE_REQ_O,
  input wire BUSY_O,
  input wire FRAME_DONE_O
);
  int va_n;
  int vb_n;
  int h_n;
  int l_n;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // Counters restart at frame start, so a short frame shows up as a wrong count at done
  always @(posedge CLK_I) begin
    va_n <= VERT_PHASE_A_O ? va_n + 1 : 0;
    vb_n <= VERT_PHASE_B_O ? vb_n + 1 : 0;
    if (RST_I || $rose(BUSY_O)) begin
      h_n <= 0;
      l_n <= 0;
    end else if ($fell(VERT_PHASE_B_O)) begin
      h_n <= 0;
      l_n <= l_n + 1;
    end else if ($rose(HORIZ_PHASE_B_O)) begin
      h_n <= h_n + 1;
    end
  end
  sequence s_va_end;
    $fell(VERT_PHASE_A_O);
  endsequence
  sequence s_taken;
    SAMPLE_REQ_O ##1 !SAMPLE_REQ_O;
  endsequence
  property p_compl; HORIZ_PHASE_A_O != HORIZ_PHASE_B_O; endproperty
  property p_vb_ha; $fell(VERT_PHASE_B_O) |-> HORIZ_PHASE_A_O && !VERT_PHASE_A_O; endproperty
  property p_integ; !BUSY_O |-> !VERT_PHASE_A_O && !VERT_PHASE_B_O; endproperty
  property p_va_w; s_va_end |-> va_n >= VPULSE_CYC && VERT_PHASE_B_O; endproperty
  property p_vb_w; $fell(VERT_PHASE_B_O) |-> vb_n >= VPULSE_CYC; endproperty
  property p_noshift; VERT_PHASE_A_O || VERT_PHASE_B_O |-> HORIZ_PHASE_A_O && !SAMPLE_REQ_O; endproperty
  property p_line_pix; $rose(VERT_PHASE_A_O) && l_n > 0 |-> h_n == LINE_PIX; endproperty
  property p_frame; FRAME_DONE_O |-> l_n == FRAME_LINES && h_n == LINE_PIX; endproperty
  property p_clr; s_taken |-> DIFFUSION_CLEAR_GATE_O; endproperty
  a_compl: assert property (p_compl) else $error("horizontal phases equal");
  a_vb_ha: assert property (p_vb_ha) else $error("line load without phase a high");
  a_integ: assert property (p_integ) else $error("vertical phase high while idle");
  a_va_w: assert property (p_va_w) else $error("vertical phase a pulse short");
  a_vb_w: assert property (p_vb_w) else $error("vertical phase b pulse short");
  a_noshift: assert property (p_noshift) else $error("shift during vertical transfer");
  a_line_pix: assert property (p_line_pix) else $error("line not fully shifted");
  a_frame: assert property (p_frame) else $error("frame size wrong at done");
  a_clr: assert property (p_clr) else $error("no clear after sample");
endmodule // ccdr_readout_sva

// ==== verif/ccdr_sensor_model.sv ====
// Purpose: Sensor plus converter on the far side of the sequencer.
// Assumes: Sample word is {line, pixel} so the bench can predict it.
// Notes: Data inverts when valid drops, so a stale word never matches.
`timescale 1ns/1ns
module ccdr_sensor_model #(
  parameter FRAME_LINES = 32
) (
  input wire clk_i,
  input wire rst_i,
  input wire vert_phase_b_i,
  input wire sample_req_i,
  input wire slow_i,
  output reg sample_valid_o,
  output reg [15:0] sample_data_o
);
  localparam [7:0] LAST = FRAME_LINES - 1;
  reg vb_q;
  reg [7:0] line;
  reg [7:0] pix;
  int dly;
  always @(posedge clk_i) begin
    vb_q <= vert_phase_b_i;
    if (rst_i) begin
      line <= LAST;
      pix <= 8'h00;
      dly <= 0;
      sample_valid_o <= 1'b0;
      sample_data_o <= 16'h0000;
    end else if (vb_q && !vert_phase_b_i) begin
      line <= (line == LAST) ? 8'h00 : line + 8'h01;
      pix <= 8'h00;
    end else if (sample_valid_o && !sample_req_i) begin
      sample_valid_o <= 1'b0;
      sample_data_o <= ~sample_data_o;
      pix <= pix + 8'h01;
    end else if (sample_req_i && !sample_valid_o) begin
      dly <= dly + 1;
      if (dly >= (slow_i ? 9 : 0)) begin
        dly <= 0;
        sample_valid_o <= 1'b1;
        sample_data_o <= {line, pix};
      end
    end
  end
endmodule // ccdr_sensor_model

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the frame readout sequencer.
// Assumes: Shortened frame of 44 pixels by 32 lines.
// Notes: The sink stalls long enough mid-frame to fill the FIFO.
`timescale 1ns/1ns
`include "ccdr_defs.vh"
module tb_top;
  localparam LP = 44;
  localparam FL = 32;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg start = 1'b0;
  reg ready = 1'b1;
  reg slow = 1'b0;
  wire [15:0] sdata;
  wire [15:0] dref;
  wire [19:0] pdata;
  wire svalid, vert_a, vert_b, horiz_a, horiz_b, clr, sreq, pvalid, busy, done;
  int error_cnt = 0;
  int compares = 0;
  int l_x, p_x, n_x;
  bit timed_out = 1'b0;
  always #4 clk = ~clk;
  ccdr_readout #(.VPULSE_CYC(4), .HHALF_CYC(2), .LINE_PIX(LP), .FRAME_LINES(FL)) dut (
    .CLK_I(clk), .RST_I(rst), .START_I(start), .SAMPLE_DATA_I(sdata), .SAMPLE_VALID_I(svalid),
    .PIX_READY_I(ready), .VERT_PHASE_A_O(vert_a), .VERT_PHASE_B_O(vert_b), .HORIZ_PHASE_A_O(horiz_a),
    .HORIZ_PHASE_B_O(horiz_b), .DIFFUSION_CLEAR_GATE_O(clr), .SAMPLE_REQ_O(sreq), .PIX_VALID_O(pvalid),
    .PIX_DATA_O(pdata), .BUSY_O(busy), .FRAME_DONE_O(done), .DARK_REF_O(dref));
  ccdr_sensor_model #(.FRAME_LINES(FL)) model (.clk_i(clk), .rst_i(rst), .vert_phase_b_i(vert_b),
    .sample_req_i(sreq), .slow_i(slow), .sample_valid_o(svalid), .sample_data_o(sdata));
  task chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [2:0] cls(int l, int p);
    logic [2:0] c;
    c = p < 11 ? 3'h0 : p < 15 ? 3'h1 : p < 35 ? 3'h2 : (p == 35 || p == LP - 4) ? 3'h3 : p > LP - 4 ? 3'h1 : 3'h4;
    if (c == 3'h4 && (l < 20 || l >= FL - 9))
      c = 3'h2;
    else if (c == 3'h4 && (l == 20 || l == FL - 10))
      c = 3'h3;
    return c;
  endfunction
  always @(posedge clk) begin
    if (pvalid === 1'b1 && ready) begin
      chk("pixel", {1'b0, cls(l_x, p_x), l_x[7:0], p_x[7:0]}, pdata);
      n_x++;
      p_x = (p_x == LP - 1) ? 0 : p_x + 1;
      l_x = (p_x == 0) ? l_x + 1 : l_x;
    end
  end
  task end_of_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Start is held through part of the frame; a restart at done would leave busy high
  task run_frame(input int stall);
    int i;
    int s;
    l_x = 0;
    p_x = 0;
    n_x = 0;
    start = 1'b1;
    repeat (300) @(negedge clk);
    if (stall > 0) begin
      ready = 1'b0;
      repeat (stall) @(negedge clk);
      chk("request held while full", 20'h1, {19'h0, sreq});
      ready = 1'b1;
    end
    start = 1'b0;
    for (i = 0; i < 60000 && done !== 1'b1; i++)
      @(negedge clk);
    if (done !== 1'b1) begin
      error_cnt++;
      timed_out = 1'b1;
      return;
    end
    repeat (10) @(negedge clk);
    chk("pixels", 20'(LP * FL), 20'(n_x));
    chk("idle", 20'h0, {17'h0, busy, vert_a, vert_b});
    s = 0;
    for (i = 0; i < LP; i++)
      s += (cls(19, i) == `CCDR_CLASS_DARK) ? 16'h1300 + i : 0;
    chk("dark reference", {4'h0, s[20:5]}, {4'h0, dref});
  endtask
  task t_reset;
    repeat (2) @(negedge clk);
    chk("reset pins", 20'h00020, {12'h0, vert_a, vert_b, horiz_a, horiz_b, clr, sreq, busy, done});
  endtask
  task t_frame_stall;
    slow = 1'b0;
    run_frame(400);
  endtask
  task t_frame_slow;
    slow = 1'b1;
    run_frame(0);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_frame_stall;
    if (!timed_out)
      t_frame_slow;
    end_of_test;
  end
endmodule // tb_top
bind ccdr_readout ccdr_readout_sva #(.VPULSE_CYC(VPULSE_CYC), .LINE_PIX(LINE_PIX), .FRAME_LINES(FRAME_LINES)) chk_i (
  .CLK_I(CLK_I), .RST_I(RST_I), .VERT_PHASE_A_O(VERT_PHASE_A_O), .VERT_PHASE_B_O(VERT_PHASE_B_O),
  .HORIZ_PHASE_A_O(HORIZ_PHASE_A_O), .HORIZ_PHASE_B_O(HORIZ_PHASE_B_O), .SAMPLE_REQ_O(SAMPLE_REQ_O),
  .DIFFUSION_CLEAR_GATE_O(DIFFUSION_CLEAR_GATE_O), .BUSY_O(BUSY_O), .FRAME_DONE_O(FRAME_DONE_O));
